// *** src/eipc_map.svh ***
// Purpose: Register offsets, field positions and reset values of the edge/priority block
// Assumes: Wishbone word addresses, 8-bit registers in the low byte
// Notes: Definitions only
`ifndef EIPC_MAP_SVH
`define EIPC_MAP_SVH
`define EIPC_ADR_CTRL2 8'h00
`define EIPC_ADR_CTRL3 8'h04
`define EIPC_ADR_SRC 8'h08
`define EIPC_ADR_STS 8'h0c
`define EIPC_ADR_MSK 8'h10
`define EIPC_ADR_SVC 8'h14
`define EIPC_RST_CTRL2 8'hf5
`define EIPC_RST_CTRL3 8'hc0
`define EIPC_RST_SRC 8'h00
`define EIPC_WMASK_CTRL2 8'hf5
`define EIPC_WMASK_CTRL3 8'hdb
`define EIPC_C2_PULLUP 7
`define EIPC_C2_EDG0 6
`define EIPC_C2_EDG1 5
`define EIPC_C2_EDG2 4
`define EIPC_C2_TMR0_PRIO 2
`define EIPC_C2_PORT_PRIO 0
`define EIPC_C3_IRQ2_PRIO 7
`define EIPC_C3_IRQ1_PRIO 6
`define EIPC_C3_IRQ2_EN 4
`define EIPC_C3_IRQ1_EN 3
`define EIPC_C3_IRQ2_FLAG 1
`define EIPC_C3_IRQ1_FLAG 0
`define EIPC_SRC_GLOB_HIGH 7
`define EIPC_SRC_GLOB_LOW 6
`define EIPC_SRC_TMR0_EN 5
`define EIPC_SRC_IRQ0_EN 4
`define EIPC_SRC_PORT_EN 3
`define EIPC_SRC_TMR0_FLAG 2
`define EIPC_SRC_IRQ0_FLAG 1
`define EIPC_SRC_PORT_FLAG 0
`define EIPC_EV_IRQ0 0
`define EIPC_EV_IRQ1 1
`define EIPC_EV_IRQ2 2
`define EIPC_EV_TMR0 3
`define EIPC_EV_PORT 4
`define EIPC_VEC_HIGH 24'h000008
`define EIPC_VEC_LOW 24'h000018
`define EIPC_VEC_NONE 24'h000000
`endif

// *** src/eipc_pkg.sv ***
// Purpose: Types shared by the edge/priority block
// Assumes: Used together with eipc_map.svh
// Notes: Service state tracks nesting of high over low
package eipc_pkg;
    typedef enum logic [1:0] {
        EIPC_IDLE,
        EIPC_LOW,
        EIPC_HIGH,
        EIPC_HIGH_OVER_LOW
    } eipc_svc_t;

    typedef struct packed {
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] src;
        logic [4:0] sts;
        logic [4:0] msk;
        logic [2:0] line_prev;
        logic armed;
        eipc_svc_t svc;
        logic [23:0] vec;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic req_high;
        logic req_low;
    } eipc_state_t;
endpackage

// *** src/eipc_ctrl.sv ***
// Purpose: External edge interrupts, priority selection and vectoring, Wishbone registers
// Assumes: Pins and core strobes synchronous to clk_i
// Notes: 8-bit registers sit in the low byte of each 32-bit word
// Notes on behaviour
// - Edge select 0 picks rising (1) or falling (0) edges on external line zero.
// - Edge select 1 picks rising (1) or falling (0) edges on external line one.
// - Edge select 2 picks rising (1) or falling (0) edges on external line two.
// - Bit 0 of control two sends the port-change source to high priority when set.
// - Every flag is set by its event whatever its enable or the global enables.
// - A taken interrupt loads the high or low vector according to the source priority.
// - High requests preempt a low routine; low requests wait during a high routine.
`timescale 1ns/1ns
`include "eipc_map.svh"
`default_nettype none

module eipc_ctrl
    import eipc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_irq_line_zero_i,
    input wire logic ext_irq_line_one_i,
    input wire logic ext_irq_line_two_i,
    input wire logic timer0_overflow_i,
    input wire logic port_change_i,
    input wire logic core_take_i,
    input wire logic core_return_i,
    output logic irq_high_req_o,
    output logic irq_low_req_o,
    output logic [23:0] vector_o,
    output logic port_b_pullup_disable_o,
    output logic irq_o
);

    eipc_state_t st_ff;
    eipc_state_t nxt_st;

    // Edge hit on one line: sel high means rising
    function automatic logic edge_hit(input logic cur, input logic prev, input logic sel);
        edge_hit = sel ? (cur & ~prev) : (~cur & prev);
    endfunction

    // Sticky flag: an event in the cycle of a clear still wins
    function automatic logic flag_next(input logic cur, input logic wr,
                                       input logic val, input logic ev);
        flag_next = (wr ? val : cur) | ev;
    endfunction

    logic [2:0] lines;
    logic [4:0] ev;
    logic [4:0] en;
    logic [4:0] prio;
    logic [4:0] flg;
    logic bus_req;
    logic wr_now;
    logic wr_c2;
    logic wr_c3;
    logic wr_src;
    logic wr_sts;
    logic wr_msk;
    logic pend_high;
    logic pend_low;
    logic [7:0] rd;

    assign lines = {ext_irq_line_two_i, ext_irq_line_one_i, ext_irq_line_zero_i};

    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i;
        // Write lands on the edge where the master sees ack
        wr_now = bus_req & wb_we_i & st_ff.ack & wb_sel_i[0];
        wr_c2 = 1'b0;
        wr_c3 = 1'b0;
        wr_src = 1'b0;
        wr_sts = 1'b0;
        wr_msk = 1'b0;
        if (wb_adr_i == `EIPC_ADR_CTRL2) begin
            wr_c2 = wr_now;
        end else if (wb_adr_i == `EIPC_ADR_CTRL3) begin
            wr_c3 = wr_now;
        end else if (wb_adr_i == `EIPC_ADR_SRC) begin
            wr_src = wr_now;
        end else if (wb_adr_i == `EIPC_ADR_STS) begin
            wr_sts = wr_now;
        end else if (wb_adr_i == `EIPC_ADR_MSK) begin
            wr_msk = wr_now;
        end

        // No external line edge is detected in the first cycle after reset: no prior level yet
        ev = 5'h00;
        ev[`EIPC_EV_IRQ0] = st_ff.armed & edge_hit(lines[0], st_ff.line_prev[0],
                            st_ff.ctrl2[`EIPC_C2_EDG0]);
        ev[`EIPC_EV_IRQ1] = st_ff.armed & edge_hit(lines[1], st_ff.line_prev[1],
                            st_ff.ctrl2[`EIPC_C2_EDG1]);
        ev[`EIPC_EV_IRQ2] = st_ff.armed & edge_hit(lines[2], st_ff.line_prev[2],
                            st_ff.ctrl2[`EIPC_C2_EDG2]);
        ev[`EIPC_EV_TMR0] = timer0_overflow_i;
        ev[`EIPC_EV_PORT] = port_change_i;

        en = 5'h00;
        en[`EIPC_EV_IRQ0] = st_ff.src[`EIPC_SRC_IRQ0_EN];
        en[`EIPC_EV_IRQ1] = st_ff.ctrl3[`EIPC_C3_IRQ1_EN];
        en[`EIPC_EV_IRQ2] = st_ff.ctrl3[`EIPC_C3_IRQ2_EN];
        en[`EIPC_EV_TMR0] = st_ff.src[`EIPC_SRC_TMR0_EN];
        en[`EIPC_EV_PORT] = st_ff.src[`EIPC_SRC_PORT_EN];

        // Line zero has no priority bit and is always high
        prio = 5'h00;
        prio[`EIPC_EV_IRQ0] = 1'b1;
        prio[`EIPC_EV_IRQ1] = st_ff.ctrl3[`EIPC_C3_IRQ1_PRIO];
        prio[`EIPC_EV_IRQ2] = st_ff.ctrl3[`EIPC_C3_IRQ2_PRIO];
        prio[`EIPC_EV_TMR0] = st_ff.ctrl2[`EIPC_C2_TMR0_PRIO];
        prio[`EIPC_EV_PORT] = st_ff.ctrl2[`EIPC_C2_PORT_PRIO];

        flg = 5'h00;
        flg[`EIPC_EV_IRQ0] = st_ff.src[`EIPC_SRC_IRQ0_FLAG];
        flg[`EIPC_EV_IRQ1] = st_ff.ctrl3[`EIPC_C3_IRQ1_FLAG];
        flg[`EIPC_EV_IRQ2] = st_ff.ctrl3[`EIPC_C3_IRQ2_FLAG];
        flg[`EIPC_EV_TMR0] = st_ff.src[`EIPC_SRC_TMR0_FLAG];
        flg[`EIPC_EV_PORT] = st_ff.src[`EIPC_SRC_PORT_FLAG];

        // A flag already set when its enable rises requests at once
        pend_high = st_ff.src[`EIPC_SRC_GLOB_HIGH] & (|(flg & en & prio));
        // Low requests are held back while any routine, high or low, runs
        pend_low = st_ff.src[`EIPC_SRC_GLOB_LOW] & (|(flg & en & ~prio))
                   & (st_ff.svc == EIPC_IDLE);

        rd = 8'h00;
        if (wb_adr_i == `EIPC_ADR_CTRL2) begin
            rd = st_ff.ctrl2;
        end else if (wb_adr_i == `EIPC_ADR_CTRL3) begin
            rd = st_ff.ctrl3;
        end else if (wb_adr_i == `EIPC_ADR_SRC) begin
            rd = st_ff.src;
        end else if (wb_adr_i == `EIPC_ADR_STS) begin
            rd = {3'h0, st_ff.sts};
        end else if (wb_adr_i == `EIPC_ADR_MSK) begin
            rd = {3'h0, st_ff.msk};
        end else if (wb_adr_i == `EIPC_ADR_SVC) begin
            rd = {6'h00, st_ff.svc};
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.line_prev = lines;
        nxt_st.armed = 1'b1;

        // Classic slave: ack one cycle after the request, dropped the cycle after
        nxt_st.ack = bus_req & ~st_ff.ack;
        if (bus_req & ~st_ff.ack) begin
            nxt_st.dat = {24'h000000, rd};
        end

        if (wr_c2) begin
            nxt_st.ctrl2 = wb_dat_i[7:0] & `EIPC_WMASK_CTRL2;
        end

        // Enables and priorities of control three follow the write; flags below
        if (wr_c3) begin
            nxt_st.ctrl3 = (wb_dat_i[7:0] & `EIPC_WMASK_CTRL3);
        end
        nxt_st.ctrl3[`EIPC_C3_IRQ1_FLAG] = flag_next(st_ff.ctrl3[`EIPC_C3_IRQ1_FLAG], wr_c3,
            wb_dat_i[`EIPC_C3_IRQ1_FLAG], ev[`EIPC_EV_IRQ1]);
        nxt_st.ctrl3[`EIPC_C3_IRQ2_FLAG] = flag_next(st_ff.ctrl3[`EIPC_C3_IRQ2_FLAG], wr_c3,
            wb_dat_i[`EIPC_C3_IRQ2_FLAG], ev[`EIPC_EV_IRQ2]);

        if (wr_src) begin
            nxt_st.src = wb_dat_i[7:0];
        end
        nxt_st.src[`EIPC_SRC_IRQ0_FLAG] = flag_next(st_ff.src[`EIPC_SRC_IRQ0_FLAG], wr_src,
            wb_dat_i[`EIPC_SRC_IRQ0_FLAG], ev[`EIPC_EV_IRQ0]);
        nxt_st.src[`EIPC_SRC_TMR0_FLAG] = flag_next(st_ff.src[`EIPC_SRC_TMR0_FLAG], wr_src,
            wb_dat_i[`EIPC_SRC_TMR0_FLAG], ev[`EIPC_EV_TMR0]);
        nxt_st.src[`EIPC_SRC_PORT_FLAG] = flag_next(st_ff.src[`EIPC_SRC_PORT_FLAG], wr_src,
            wb_dat_i[`EIPC_SRC_PORT_FLAG], ev[`EIPC_EV_PORT]);

        // Status is write-one-to-clear, events win over the clear
        nxt_st.sts = (st_ff.sts & ~(wr_sts ? wb_dat_i[4:0] : 5'h00)) | ev;
        if (wr_msk) begin
            nxt_st.msk = wb_dat_i[4:0];
        end
        nxt_st.irq = |(nxt_st.sts & nxt_st.msk);

        // Vector is loaded on the take strobe, high first
        case (st_ff.svc)
            EIPC_IDLE: begin
                if (core_take_i & pend_high) begin
                    nxt_st.svc = EIPC_HIGH;
                    nxt_st.vec = `EIPC_VEC_HIGH;
                end else if (core_take_i & pend_low) begin
                    nxt_st.svc = EIPC_LOW;
                    nxt_st.vec = `EIPC_VEC_LOW;
                end
            end
            EIPC_LOW: begin
                if (core_take_i & pend_high) begin
                    nxt_st.svc = EIPC_HIGH_OVER_LOW;
                    nxt_st.vec = `EIPC_VEC_HIGH;
                end else if (core_return_i) begin
                    nxt_st.svc = EIPC_IDLE;
                end
            end
            EIPC_HIGH: begin
                if (core_return_i) begin
                    nxt_st.svc = EIPC_IDLE;
                end
            end
            default: begin
                if (core_return_i) begin
                    nxt_st.svc = EIPC_LOW;
                end
            end
        endcase

        // Requests only while nothing of equal or higher rank is in service
        nxt_st.req_high = pend_high & (nxt_st.svc != EIPC_HIGH)
                          & (nxt_st.svc != EIPC_HIGH_OVER_LOW);
        nxt_st.req_low = pend_low & (nxt_st.svc == EIPC_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.ctrl2 <= `EIPC_RST_CTRL2;
            st_ff.ctrl3 <= `EIPC_RST_CTRL3;
            st_ff.src <= `EIPC_RST_SRC;
            st_ff.sts <= 5'h00;
            st_ff.msk <= 5'h00;
            st_ff.line_prev <= 3'h0;
            st_ff.armed <= 1'b0;
            st_ff.svc <= EIPC_IDLE;
            st_ff.vec <= `EIPC_VEC_NONE;
            st_ff.ack <= 1'b0;
            st_ff.dat <= 32'h00000000;
            st_ff.irq <= 1'b0;
            st_ff.req_high <= 1'b0;
            st_ff.req_low <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq_high_req_o = st_ff.req_high;
    assign irq_low_req_o = st_ff.req_low;
    assign vector_o = st_ff.vec;
    assign port_b_pullup_disable_o = st_ff.ctrl2[`EIPC_C2_PULLUP];
    assign irq_o = st_ff.irq;

endmodule

`default_nettype wire

// *** dv/eipc_ctrl_chk.sv ***
// Purpose: Port-level assertions for the edge/priority block
// Assumes: Bound to every eipc_ctrl instance
// Notes: Sees only top ports, so vectoring and bus timing are checked here
`timescale 1ns/1ns
`default_nettype none
module eipc_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic core_take_i,
    input wire logic irq_high_req_o,
    input wire logic irq_low_req_o,
    input wire logic [23:0] vector_o,
    input wire logic port_b_pullup_disable_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper data set");
    AST_VEC_HIGH: assert property (core_take_i && irq_high_req_o |=>
        vector_o == 24'h000008 && !irq_high_req_o) else $error("high vector wrong");
    AST_VEC_LOW: assert property (core_take_i && !irq_high_req_o && irq_low_req_o |=>
        vector_o == 24'h000018 && !irq_low_req_o) else $error("low vector wrong");
    AST_VEC_HOLD: assert property (!core_take_i |=> $stable(vector_o))
        else $error("vector moved");
    AST_LOW_WAIT: assert property (core_take_i && irq_high_req_o |=> !irq_low_req_o)
        else $error("low request during high");
    AST_RST_VAL: assert property ($fell(rst_i) |-> port_b_pullup_disable_o && !irq_o
        && vector_o == 24'h000000) else $error("reset values wrong");
    cover property (core_take_i && irq_high_req_o);
    cover property (core_take_i && irq_low_req_o && !irq_high_req_o);
    cover property (irq_o);
endmodule
bind eipc_ctrl eipc_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_take_i(core_take_i),
    .irq_high_req_o(irq_high_req_o), .irq_low_req_o(irq_low_req_o), .vector_o(vector_o),
    .port_b_pullup_disable_o(port_b_pullup_disable_o), .irq_o(irq_o));
`default_nettype wire

// *** dv/eipc_core_mdl.sv ***
// Purpose: Behavioural core that takes and returns from interrupts
// Assumes: go_i is raised by the bench only when a take is wanted
// Notes: A late go_i models a busy core that leaves requests waiting
`timescale 1ns/1ns
`default_nettype none
module eipc_core_mdl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic ret_i,
    input wire logic high_req_i,
    input wire logic low_req_i,
    output logic take_o,
    output logic return_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            take_o <= 1'b0;
            return_o <= 1'b0;
        end else begin
            // One take per go, since the request only drops at the take edge
            take_o <= go_i && !take_o && (high_req_i || low_req_i);
            return_o <= ret_i && !take_o;
        end
    end
endmodule
`default_nettype wire

// *** dv/eipc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the edge/priority block
// Assumes: Core model takes only when go is raised
// Notes: Row table covers register access; edges and vectoring follow by hand
`timescale 1ns/1ns
`default_nettype none
module eipc_ctrl_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, ack, irq, pud;
    logic tmr = 1'b0, port = 1'b0, go = 1'b0, ret = 1'b0, take, rtn, hreq, lreq;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rd, rdat;
    logic [2:0] lines = 3'h0;
    logic [23:0] vec;
    int failures = 0, num_checks = 0, cycles = 0;
    // Address, value read before the write, value written
    logic [23:0] rows [13] = '{24'h0c001f, 24'h10001f, 24'h1400ff, 24'h1800ff, 24'h00f5ff,
        24'h04c0ff, 24'h0800ff, 24'h00f500, 24'h04db00, 24'h08ff00, 24'h101f00, 24'h140000,
        24'h180000};
    eipc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
        .ext_irq_line_zero_i(lines[0]), .ext_irq_line_one_i(lines[1]),
        .ext_irq_line_two_i(lines[2]), .timer0_overflow_i(tmr), .port_change_i(port),
        .core_take_i(take), .core_return_i(rtn), .irq_high_req_o(hreq), .irq_low_req_o(lreq),
        .vector_o(vec), .port_b_pullup_disable_o(pud), .irq_o(irq));
    eipc_core_mdl core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ret_i(ret),
        .high_req_i(hreq), .low_req_i(lreq), .take_o(take), .return_o(rtn));
    always #5 clk_i = ~clk_i;
    task automatic give_verdict();
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Values seen right after an edge are the ones the design sampled there
    // Waits for ack with no cycle limit of its own; only the bench timeout ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = rd;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdat, e);
    endtask
    task automatic take_one();
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(3);
    endtask
    initial begin
        tick(8);
        rst_i <= 1'b0;
        foreach (rows[k]) begin
            rdc(rows[k][23:16], {24'h0, rows[k][15:8]});
            wr(rows[k][23:16], rows[k][7:0]);
        end
        chk(pud, 1'b0);
        // A write with the low byte lane off must leave the register alone
        sel <= 4'he;
        wr(8'h10, 8'h1f);
        sel <= 4'hf;
        rdc(8'h10, 32'h0);
        for (int i = 0; i < 3; i++) begin
            for (int e = 0; e < 2; e++) begin
                wr(8'h00, 8'(e << (6 - i)));
                lines[i] <= e[0];
                wr(8'h04, 8'h00);
                wr(8'h08, 8'h00);
                wr(8'h0c, 8'h1f);
                lines[i] <= !e[0];
                rdc(8'h0c, 32'h0);
                lines[i] <= e[0];
                rdc(8'h0c, 32'(1 << i));
                rdc(i == 0 ? 8'h08 : 8'h04, i == 0 ? 32'h2 : 32'(1 << (i - 1)));
                tick(1);
                chk(irq, 1'b0);
                wr(8'h10, 8'(1 << i));
                tick(1);
                chk(irq, 1'b1);
                wr(8'h0c, 8'h1f);
                tick(1);
                chk(irq, 1'b0);
                wr(8'h10, 8'h00);
            end
        end
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h01);
        wr(8'h08, 8'hc8);
        port <= 1'b1;
        tick(1);
        port <= 1'b0;
        tick(3);
        chk({hreq, lreq}, 2'b10);
        take_one();
        chk(vec, 24'h000008);
        rdc(8'h14, 32'h2);
        wr(8'h08, 8'hc8);
        ret <= 1'b1;
        tick(1);
        ret <= 1'b0;
        tick(3);
        chk({hreq, lreq}, 2'b00);
        wr(8'h00, 8'h00);
        port <= 1'b1;
        tick(1);
        port <= 1'b0;
        tick(3);
        chk({hreq, lreq}, 2'b01);
        take_one();
        chk(vec, 24'h000018);
        wr(8'h00, 8'h04);
        wr(8'h08, 8'he9);
        tmr <= 1'b1;
        tick(1);
        tmr <= 1'b0;
        tick(3);
        chk(hreq, 1'b1);
        take_one();
        chk({vec, lreq}, {24'h000008, 1'b0});
        rdc(8'h14, 32'h3);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        chk({pud, vec, hreq, lreq, irq}, {1'b1, 24'h000000, 3'h0});
        // Lines stand high with rising edges selected: no false edge after reset
        rdc(8'h0c, 32'h0);
        rdc(8'h00, 32'hf5);
        give_verdict();
    end
endmodule
`default_nettype wire
